// ---- rtl/eft_pkg.sv ----
package eft_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_BANK = 7'h01;
  localparam logic [6:0] IDX_PAGE_SEL = 7'h02;
  localparam logic [6:0] IDX_FN_EN_B = 7'h05;
  localparam logic [6:0] IDX_PAGE_PTR = 7'h08;
  localparam logic [6:0] IDX_PAGE_DATA = 7'h09;
  localparam logic [6:0] IDX_IRQ_ROUTE = 7'h0F;
  localparam logic [6:0] IDX_ACCEL = 7'h10;
  localparam logic [6:0] IDX_GYRO = 7'h11;
  localparam logic [6:0] IDX_CHARGE = 7'h16;
  localparam logic [6:0] IDX_PAGE_RW = 7'h17;
  localparam logic [6:0] IDX_PROG_EN = 7'h46;
  localparam logic [6:0] IDX_RATE_PIN2 = 7'h5F;
  localparam logic [6:0] IDX_STATUS = 7'h30;
  localparam logic [6:0] IDX_POINTERS = 7'h31;

  // control bits and values
  localparam int BANK_OPEN_BIT = 7;
  localparam int PAGE_WR_BIT = 6;
  localparam int CHARGE_EN_BIT = 7;
  localparam int MACHINE_EN_BIT = 0;
  localparam int PROG0_EN_BIT = 0;
  localparam int ROUTE0_BIT = 0;
  localparam int PIN2_EMB_BIT = 1;
  localparam logic [3:0] PAGE_ADV = 4'h1;
  localparam logic [7:0] ADV_COUNT = 8'h7C;
  localparam logic [7:0] ADV_START_L = 8'h7E;
  localparam logic [7:0] ADV_START_H = 8'h7F;
  localparam logic [11:0] PROG_BASE = 12'h400;

  // program image layout
  localparam logic [7:0] IMG_RPTR = 8'h04;
  localparam logic [7:0] IMG_PPTR = 8'h05;
  localparam logic [7:0] IMG_THR_L = 8'h06;
  localparam logic [7:0] IMG_THR_H = 8'h07;
  localparam logic [7:0] IMG_MASK_A = 8'h08;
  localparam logic [7:0] IMG_MASK_B = 8'h0A;
  localparam logic [7:0] IMG_MASK_C = 8'h0C;
  localparam logic [7:0] IMG_TIMER3 = 8'h0F;
  localparam logic [7:0] RPTR_DEFAULT = 8'h10;

  // instruction codes
  localparam logic [7:0] OP_STOP = 8'h00;
  localparam logic [7:0] OP_CONT_REL = 8'h22;
  localparam logic [7:0] OP_IN_SEL = 8'h23;
  localparam logic [7:0] OP_SET_RPTR = 8'h33;
  localparam logic [7:0] OP_CLR_RPTR = 8'h44;
  localparam logic [7:0] OP_ABOVE_TI = 8'h53;
  localparam logic [7:0] OP_SEL_A = 8'h66;
  localparam logic [7:0] OP_BELOW_TI = 8'h73;
  localparam logic [7:0] OP_SEL_B = 8'h77;
  localparam logic [7:0] OP_SEL_C = 8'h88;
  localparam logic [7:0] OP_OUT_CONT = 8'h99;
  localparam logic [7:0] IN_EXT = 8'h02;

  typedef enum logic [1:0] {RUN_IDLE, RUN_EXEC, RUN_STOP} eft_run_t;
  typedef enum logic [1:0] {MASK_A, MASK_B, MASK_C} eft_mask_t;
endpackage : eft_pkg

// ---- rtl/eft_machine.sv ----
`timescale 1ns/1ps
module eft_machine
  import eft_pkg::*;
#(
  parameter int IMG_DEPTH = 64,
  parameter int ADDR_W = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic [15:0] ext_x_sample,
  input wire logic [15:0] charge_sample,
  output logic second_irq_pin,
  output logic [7:0] output_status,
  output logic machine_running
);
  import eft_pkg::*;

  localparam int IMG_AW = $clog2(IMG_DEPTH);
  typedef logic [IMG_DEPTH-1:0][7:0] eft_img_t;

  typedef struct packed {
    logic [7:0] bank;
    logic [7:0] page_sel;
    logic [7:0] fn_en_b;
    logic [7:0] page_ptr;
    logic [7:0] irq_route;
    logic [7:0] accel;
    logic [7:0] gyro;
    logic [7:0] charge;
    logic [7:0] page_rw;
    logic [7:0] prog_en;
    logic [7:0] rate_cfg;
    logic [7:0] pin2_cfg;
    logic [7:0] prog_count;
    logic [7:0] start_l;
    logic [7:0] start_h;
    eft_img_t img;
    eft_run_t run;
    logic running;
    logic [7:0] pptr;
    logic [7:0] rptr;
    eft_mask_t mask;
    logic ext_in;
    logic [7:0] timer;
    logic [7:0] status;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eft_state_t;

  eft_state_t state_reg;
  eft_state_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte of the program image, addressed relative to PROG_BASE, zero beyond the image
  function automatic logic [7:0] img_byte(eft_img_t m, logic [11:0] a);
    img_byte = (a < 12'(IMG_DEPTH)) ? m[a[IMG_AW-1:0]] : 8'h00;
  endfunction : img_byte

  // half float turned into an unsigned ordering key
  function automatic logic [15:0] hfp_key(logic [15:0] v);
    hfp_key = v[15] ? ~v : (v | 16'h8000);
  endfunction : hfp_key

  ////////////////////////////////////////////////////////////////////////
  // decode and next state

  logic [6:0] idx;
  logic emb;
  logic acc;
  logic hit;
  logic [7:0] rdat;
  logic [7:0] wdat;
  logic [11:0] base;
  logic [11:0] page_addr;
  logic [11:0] prog_addr;
  logic [7:0] op;
  logic [7:0] arg;
  logic [15:0] smp;
  logic [15:0] thr;
  logic above;
  logic holds;
  logic [7:0] mask_val;
  logic go;

  always_comb
  begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.prdata = 32'h0000_0000;
    idx = paddr[8:2];
    emb = state_reg.bank[BANK_OPEN_BIT];
    acc = psel & penable & ~state_reg.pready;
    hit = 1'b1;
    rdat = 8'h00;
    wdat = pwdata[7:0];
    page_addr = {state_reg.page_sel[7:4], state_reg.page_ptr};
    prog_addr = page_addr - PROG_BASE;
    base = 12'({state_reg.start_h, state_reg.start_l} - 16'(PROG_BASE));
    op = img_byte(state_reg.img, base + 12'(state_reg.pptr));
    arg = img_byte(state_reg.img, base + 12'(state_reg.pptr) + 12'h001);
    thr = {img_byte(state_reg.img, base + 12'(IMG_THR_H)),
           img_byte(state_reg.img, base + 12'(IMG_THR_L))};
    smp = state_reg.charge[CHARGE_EN_BIT] ? charge_sample
                                          : ext_x_sample;
    above = hfp_key(smp) > hfp_key(thr);
    holds = 1'b0;
    unique case (state_reg.mask)
      MASK_A: mask_val = img_byte(state_reg.img, base + 12'(IMG_MASK_A));
      MASK_B: mask_val = img_byte(state_reg.img, base + 12'(IMG_MASK_B));
      MASK_C: mask_val = img_byte(state_reg.img, base + 12'(IMG_MASK_C));
      default: mask_val = 8'h00;
    endcase
    go = state_reg.fn_en_b[MACHINE_EN_BIT] & ~emb
       & state_reg.prog_en[PROG0_EN_BIT] & (state_reg.prog_count != 8'h00);

    // register reads and writes; embedded map only while the bank is open
    if (idx == IDX_BANK)
      rdat = state_reg.bank;
    else if (emb)
    begin
      unique case (idx)
        IDX_PAGE_SEL: rdat = state_reg.page_sel;
        IDX_FN_EN_B: rdat = state_reg.fn_en_b;
        IDX_PAGE_PTR: rdat = state_reg.page_ptr;
        IDX_PAGE_DATA: rdat = img_byte(state_reg.img, prog_addr);
        IDX_IRQ_ROUTE: rdat = state_reg.irq_route;
        IDX_PAGE_RW: rdat = state_reg.page_rw;
        IDX_PROG_EN: rdat = state_reg.prog_en;
        IDX_RATE_PIN2: rdat = state_reg.rate_cfg;
        default: hit = 1'b0;
      endcase
    end
    else
    begin
      unique case (idx)
        IDX_ACCEL: rdat = state_reg.accel;
        IDX_GYRO: rdat = state_reg.gyro;
        IDX_CHARGE: rdat = state_reg.charge;
        IDX_RATE_PIN2: rdat = state_reg.pin2_cfg;
        IDX_STATUS: rdat = state_reg.status;
        IDX_POINTERS: rdat = state_reg.pptr;
        default: hit = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:9] != '0)
      hit = 1'b0;

    // access phase answered one cycle after it starts
    if (acc)
    begin
      state_next.pready = 1'b1;
      state_next.pslverr = ~hit;
      if (!pwrite)
        state_next.prdata = {24'h00_0000, hit ? rdat : 8'h00};
      else if (hit && idx == IDX_BANK)
        state_next.bank = wdat;
      else if (hit && emb)
      begin
        unique case (idx)
          IDX_PAGE_SEL: state_next.page_sel = wdat;
          IDX_FN_EN_B: state_next.fn_en_b = wdat;
          IDX_PAGE_PTR: state_next.page_ptr = wdat;
          IDX_IRQ_ROUTE: state_next.irq_route = wdat;
          IDX_PAGE_RW: state_next.page_rw = wdat;
          IDX_PROG_EN: state_next.prog_en = wdat;
          IDX_RATE_PIN2: state_next.rate_cfg = wdat;
          IDX_PAGE_DATA:
          begin
            // store at the page address, then step it
            if (state_reg.page_rw[PAGE_WR_BIT])
            begin
              if (prog_addr < 12'(IMG_DEPTH))
                state_next.img[prog_addr[IMG_AW-1:0]] = wdat;
              else if (state_reg.page_sel[7:4] == PAGE_ADV)
              begin
                if (state_reg.page_ptr == ADV_COUNT)
                  state_next.prog_count = wdat;
                if (state_reg.page_ptr == ADV_START_L)
                  state_next.start_l = wdat;
                if (state_reg.page_ptr == ADV_START_H)
                  state_next.start_h = wdat;
              end
              state_next.page_ptr = state_reg.page_ptr + 8'h01;
            end
          end
          default: state_next.bank = state_reg.bank;
        endcase
      end
      else if (hit)
      begin
        unique case (idx)
          IDX_ACCEL: state_next.accel = wdat;
          IDX_GYRO: state_next.gyro = wdat;
          IDX_CHARGE: state_next.charge = wdat;
          IDX_RATE_PIN2: state_next.pin2_cfg = wdat;
          default: state_next.bank = state_reg.bank;
        endcase
      end
    end

    // program execution, at most one instruction per clock; compares hold until their samples arrive
    unique case (state_reg.run)
      RUN_IDLE:
      begin
        if (go)
        begin
          state_next.run = RUN_EXEC;
          state_next.rptr = img_byte(state_reg.img, base + 12'(IMG_RPTR));
          state_next.pptr = img_byte(state_reg.img, base + 12'(IMG_PPTR));
          if (state_next.pptr == 8'h00)
            state_next.pptr = state_next.rptr;
          state_next.mask = MASK_A;
          state_next.ext_in = 1'b0;
          state_next.timer = 8'h00;
        end
      end
      RUN_EXEC:
      begin
        unique case (op)
          OP_IN_SEL:
          begin
            state_next.ext_in = (arg == IN_EXT);
            state_next.pptr = state_reg.pptr + 8'h02;
          end
          OP_SEL_A:
          begin
            state_next.mask = MASK_A;
            state_next.pptr = state_reg.pptr + 8'h01;
          end
          OP_SEL_B, OP_SEL_C:
          begin
            state_next.mask = (op == OP_SEL_B) ? MASK_B : MASK_C;
            state_next.pptr = state_reg.pptr + 8'h01;
          end
          OP_SET_RPTR:
          begin
            state_next.rptr = state_reg.pptr + 8'h01;
            state_next.pptr = state_reg.pptr + 8'h01;
          end
          OP_CLR_RPTR:
          begin
            state_next.rptr = RPTR_DEFAULT;
            state_next.pptr = state_reg.pptr + 8'h01;
          end
          OP_BELOW_TI, OP_ABOVE_TI:
          begin
            // wait for a sample on the selected input
            if (sample_valid && state_reg.ext_in)
            begin
              holds = (op == OP_BELOW_TI) ? above : ~above;
              if (!holds)
              begin
                state_next.pptr = state_reg.rptr;
                state_next.timer = 8'h00;
              end
              else if (state_reg.timer + 8'h01 >=
                       img_byte(state_reg.img, base + 12'(IMG_TIMER3)))
              begin
                state_next.pptr = state_reg.pptr + 8'h01;
                state_next.timer = 8'h00;
              end
              else
                state_next.timer = state_reg.timer + 8'h01;
            end
          end
          OP_OUT_CONT:
          begin
            state_next.irq = 1'b1;
            state_next.status = mask_val;
            state_next.pptr = state_reg.pptr + 8'h01;
          end
          OP_CONT_REL:
          begin
            state_next.irq = 1'b1;
            state_next.status = mask_val;
            state_next.pptr = state_reg.rptr;
          end
          default:
            state_next.run = RUN_STOP;
        endcase
        if (!go)
          state_next.run = RUN_IDLE;
      end
      RUN_STOP:
      begin
        if (!go)
          state_next.run = RUN_IDLE;
      end
      default:
        state_next.run = RUN_IDLE;
    endcase
    // interrupt reaches the pin only with both routing bits set
    state_next.irq = state_next.irq & state_reg.irq_route[ROUTE0_BIT]
                   & state_reg.pin2_cfg[PIN2_EMB_BIT];
    state_next.running = (state_next.run == RUN_EXEC);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.run <= RUN_IDLE;
      state_reg.rptr <= RPTR_DEFAULT;
      state_reg.mask <= MASK_A;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign second_irq_pin = state_reg.irq;
  assign output_status = state_reg.status;
  assign machine_running = state_reg.running;

endmodule : eft_machine

// ---- testbench/eft_monitor.sv ----
`timescale 1ns/1ps
module eft_monitor
  import eft_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic [15:0] ext_x_sample,
  input wire logic [15:0] charge_sample,
  input wire logic second_irq_pin,
  input wire logic [7:0] output_status,
  input wire logic machine_running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  // bus answer timing
  a_ready_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_no_sel_quiet: assert property (!psel |=> !pready)
    else $error("ready without a request");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside the answer cycle");
  a_err_read_zero: assert property (
    pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_data_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  // machine outputs
  a_irq_one_pulse: assert property (
    second_irq_pin |=> !second_irq_pin)
    else $error("interrupt pulse too long");
  a_irq_from_run: assert property (
    second_irq_pin |-> $past(machine_running, 2))
    else $error("interrupt while machine idle");
  a_status_from_run: assert property (
    $changed(output_status) |-> $past(machine_running))
    else $error("status moved while machine idle");
  c_irq: cover property (second_irq_pin);
  c_err: cover property (pslverr);
  c_run: cover property ($rose(machine_running));
endmodule : eft_monitor
bind eft_machine eft_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_valid(sample_valid),
  .ext_x_sample(ext_x_sample), .charge_sample(charge_sample),
  .second_irq_pin(second_irq_pin), .output_status(output_status),
  .machine_running(machine_running));

// ---- testbench/eft_host_model.sv ----
`timescale 1ns/1ps
module eft_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // in-ear program image, header then instructions
  localparam logic [239:0] IMG = {
    80'h71_00_1E_00_10_00_00_52_80_00,
    80'h01_00_00_00_00_0A_23_02_66_33,
    80'h73_77_99_66_33_53_44_88_22_00};
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one bus transfer, held until ready is sampled
  task automatic xfer(input logic w, input logic [6:0] idx,
    input logic [7:0] d, output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    xfer(1'b1, idx, d, q, e);
  endtask : wr
  // full configuration sequence of the host
  task automatic configure();
    wr(7'h10, 8'h00);
    wr(7'h11, 8'h00);
    wr(7'h01, 8'h80);
    wr(7'h05, 8'h01);
    wr(7'h5F, 8'h4B);
    wr(7'h46, 8'h01);
    wr(7'h0F, 8'h01);
    wr(7'h17, 8'h40);
    wr(7'h02, 8'h11);
    wr(7'h08, 8'h7A);
    // counter low/high, count, dummy, start low, start high
    wr(7'h09, 8'h00);
    wr(7'h09, 8'h00);
    wr(7'h09, 8'h01);
    wr(7'h09, 8'h01);
    wr(7'h09, 8'h00);
    wr(7'h09, 8'h04);
    wr(7'h02, 8'h41);
    wr(7'h08, 8'h00);
    for (int i = 0; i < 30; i++) wr(7'h09, IMG[239-8*i -: 8]);
    wr(7'h02, 8'h01);
    wr(7'h17, 8'h00);
    wr(7'h01, 8'h00);
    wr(7'h5F, 8'h02);
    wr(7'h10, 8'h74);
    wr(7'h16, 8'hB0);
  endtask : configure
endmodule : eft_host_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import eft_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sample_valid = 1'b0, second_irq_pin, machine_running;
  logic [15:0] charge_sample = 16'h0000, ext_x_sample = 16'h5300;
  logic [7:0] output_status, irq_cnt, q;
  logic e;
  int err_total = 0, check_count = 0, cycles = 0;
  always #50 pclk = ~pclk;
  eft_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  eft_machine dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .ext_x_sample(ext_x_sample),
    .charge_sample(charge_sample), .second_irq_pin(second_irq_pin),
    .output_status(output_status), .machine_running(machine_running));
  //////////////////////////////////////////////////////////////////////////
  // interrupt pulse counter and hang guard
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) irq_cnt <= 8'h00;
    else if (second_irq_pin === 1'b1) irq_cnt <= irq_cnt + 8'h01;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // n sample ticks of one charge value, spaced out
  task automatic send(input int n, input logic [15:0] v);
    repeat (n)
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      charge_sample <= v;
      @(posedge pclk);
      sample_valid <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : send
  task automatic scen_below();
    send(9, 16'h5300);
    send(1, 16'h5200);
    send(9, 16'h5300);
    chk(irq_cnt, 8'h00);
    send(1, 16'h5300);
    chk(irq_cnt, 8'h01);
    chk(output_status, 8'h01);
  endtask : scen_below
  task automatic scen_above();
    send(5, 16'h5100);
    send(1, 16'h5280);
    send(9, 16'h5100);
    chk(irq_cnt, 8'h01);
    send(1, 16'h5100);
    chk(irq_cnt, 8'h02);
    chk(output_status, 8'h00);
    send(10, 16'h5300);
    chk(irq_cnt, 8'h03);
    chk(output_status, 8'h01);
  endtask : scen_above
  task automatic scen_regs();
    host.xfer(1'b0, 7'h16, 8'h00, q, e);
    chk({e, q[6:0]}, 8'h30);
    host.xfer(1'b0, 7'h30, 8'h00, q, e);
    chk(q, 8'h01);
    host.xfer(1'b0, 7'h20, 8'h00, q, e);
    chk({e, q[6:0]}, 8'h80);
  endtask : scen_regs
  // charge sensing off: the machine must follow the external input
  task automatic scen_ext();
    host.wr(7'h16, 8'h30);
    ext_x_sample <= 16'h5100;
    send(10, 16'h5300);
    chk(irq_cnt, 8'h04);
    chk(output_status, 8'h00);
  endtask : scen_ext
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    host.configure();
    repeat (20) @(posedge pclk);
    chk({7'h0, machine_running}, 8'h01);
    scen_below();
    scen_above();
    scen_regs();
    scen_ext();
    report_and_stop();
  end
endmodule : testbench
